// ===== rtl/cmd_header_decoder.sv
// command header decoder: classifies one header dword per accepted beat
// assumes a streamer on CLOCK_IN offering header dwords with valid/ready
//
// Behaviour
// - 2D opcode bits 28:22; setup commands 01h/03h/11h
// - 24h,25h,26h,31h pixel, scanline, glyph blits
// - 40h fill, 43h copy; 41h-42h reserved
// - 50h-59h coordinate blits, one each
// - 71h-77h inline/chroma blits; 78h-7Fh reserved
// - any unlisted 2D opcode is reserved
// - pipeline type 3h in 28:27 is 3D
// - 3D opcode 26:24, subcode 23:16; opcode 0 list
// - 3D state subcode 53h is internal state
// - 3D opcode 1h subcodes 00h-1Dh less 01h/03h/05h/09h/19h-1Bh; rest reserved
// - 2h/00h flush, 3h/00h draw; 4h-7h reserved
// - common: 0h/03h prefetch, 1h/01h-04h; 2h-7h reserved
// - codec type 2h, opcode, subcode_a, subcode_b split
// - codec opcodes 0-3 families; 4h-7h reserved
// - codec common state subcode_b 0h-6h valid
// - h264 bitstream decode object not interruptible
// - pack, smpte, m2v, inverse transform interruptible
// - client field 31:29 picks the family first
// - dword count gives total command length
`timescale 1ns/1ps
module cmd_header_decoder (
   input  wire logic                 CLOCK_IN,
   input  wire logic                 RST_B_IN,
   input  wire cmd_decode_pkg::hdr_t HEADER_IN,
   output logic                      HEADER_READY_OUT,
   input  wire logic                 DECODE_READY_IN,
   output cmd_decode_pkg::dec_t      DECODE_OUT
);

   // ****************************************
   // field split
   // ****************************************
   logic [31:0] hdr;
   logic [2:0]  client;
   logic [6:0]  blt_op;
   logic [1:0]  ptype;
   logic [2:0]  opc;
   logic [7:0]  sub;
   logic [2:0]  sub_a;
   logic [4:0]  sub_b;
   logic        accept;

   assign hdr    = HEADER_IN.header;
   assign client = hdr[cmd_decode_pkg::CLIENT_HI:cmd_decode_pkg::CLIENT_LO];
   assign blt_op = hdr[cmd_decode_pkg::BLT_OP_HI:cmd_decode_pkg::BLT_OP_LO];
   assign ptype  = hdr[cmd_decode_pkg::PTYPE_HI:cmd_decode_pkg::PTYPE_LO];
   assign opc    = hdr[cmd_decode_pkg::OPC_HI:cmd_decode_pkg::OPC_LO];
   assign sub    = hdr[cmd_decode_pkg::SUB_HI:cmd_decode_pkg::SUB_LO];
   assign sub_a  = hdr[cmd_decode_pkg::SUBA_HI:cmd_decode_pkg::SUBA_LO];
   assign sub_b  = hdr[cmd_decode_pkg::SUBB_HI:cmd_decode_pkg::SUBB_LO];

   // one-deep output stage: a new header is taken when the stage is empty or the result drains
   assign HEADER_READY_OUT = !DECODE_OUT.valid || DECODE_READY_IN;
   assign accept           = HEADER_IN.valid && HEADER_READY_OUT;

   // ****************************************
   // family maps
   // ****************************************
   logic       blt_known;
   logic [7:0] blt_index;
   logic       codec_known;
   logic       codec_int;

   blit_opcode_map blit_opcode_map_inst (
      .opcode_in     (blt_op),
      .known_out     (blt_known),
      .cmd_index_out (blt_index)
   );

   codec_opcode_map codec_opcode_map_inst (
      .opcode_in         (opc),
      .subcode_a_in      (sub_a),
      .subcode_b_in      (sub_b),
      .known_out         (codec_known),
      .interruptible_out (codec_int)
   );

   // ****************************************
   // 3d state subcode table
   // ****************************************
   // ranges with holes instead of a table: cheaper than a 256-entry map
   logic state3d_known;
   logic pipe1_known;

   always_comb begin
      state3d_known = 1'b0;
      pipe1_known   = 1'b0;
      // listed state subcodes 04h-0Dh, 10h-53h less reserved holes
      if (sub >= 8'h04 && sub <= 8'h0D && sub != 8'h0C) begin
         state3d_known = 1'b1;
      end
      if (sub >= 8'h10 && sub <= 8'h33 && sub != 8'h21 && sub != 8'h2F) begin
         state3d_known = 1'b1;
      end
      if (sub >= 8'h4C && sub <= cmd_decode_pkg::SUB_INTERNAL) begin
         state3d_known = 1'b1;
      end
      if (sub <= 8'h1D && sub != 8'h01 && sub != 8'h03 && sub != 8'h05 &&
          sub != 8'h09 && sub != 8'h19 && sub != 8'h1A && sub != 8'h1B) begin
         pipe1_known = 1'b1;
      end
   end

   // ****************************************
   // decode
   // ****************************************
   cmd_decode_pkg::dec_t dec;

   always_comb begin
      dec                = '0;
      dec.valid          = 1'b1;
      dec.engine         = cmd_decode_pkg::ENG_NONE;
      dec.length         = 16'h0001;
      case (client)
         cmd_decode_pkg::CLIENT_MEM : begin
            dec.engine = cmd_decode_pkg::ENG_MEM;
            dec.cmd_id = {8'h00, 1'b0, hdr[28:22]};
            dec.length = {10'h000, hdr[5:0]} + cmd_decode_pkg::LEN_BIAS;
         end
         cmd_decode_pkg::CLIENT_BLIT : begin
            dec.invalid = !blt_known;
            dec.engine  = cmd_decode_pkg::ENG_BLIT;
            dec.cmd_id  = {8'h20, blt_index};
            dec.length  = {8'h00, hdr[cmd_decode_pkg::LEN8_HI:0]} +
                          cmd_decode_pkg::LEN_BIAS;
         end
         cmd_decode_pkg::CLIENT_PIPE : begin
            dec.cmd_id = {2'b00, ptype, 1'b0, opc, sub};
            dec.length = hdr[cmd_decode_pkg::LEN8_HI:0] + cmd_decode_pkg::LEN_BIAS;
            case (ptype)
               cmd_decode_pkg::PTYPE_3D : begin
                  dec.engine = cmd_decode_pkg::ENG_3D;
                  case (opc)
                     3'h0 : begin
                        dec.invalid        = !state3d_known;
                        dec.internal_state = (sub == cmd_decode_pkg::SUB_INTERNAL);
                     end
                     3'h1 : dec.invalid = !pipe1_known;
                     3'h2, 3'h3 : dec.invalid = (sub != 8'h00);
                     default : dec.invalid = 1'b1;
                  endcase
               end
               cmd_decode_pkg::PTYPE_COMMON : begin
                  dec.engine = cmd_decode_pkg::ENG_COMMON;
                  case (opc)
                     3'h0 : dec.invalid = (sub != 8'h03);
                     3'h1 : dec.invalid = (sub < 8'h01) || (sub > 8'h04);
                     default : dec.invalid = 1'b1;
                  endcase
               end
               cmd_decode_pkg::PTYPE_CODEC : begin
                  dec.engine        = cmd_decode_pkg::ENG_CODEC;
                  dec.invalid       = !codec_known;
                  dec.interruptible = codec_int;
                  dec.cmd_id        = {2'b01, ptype, 1'b0, opc, sub_a, sub_b};
                  dec.length        = hdr[cmd_decode_pkg::LEN16_HI:0] +
                                      cmd_decode_pkg::LEN_BIAS;
               end
               default : dec.invalid = 1'b1;
            endcase
         end
         default : dec.invalid = 1'b1;
      endcase
      if (dec.invalid) begin
         dec.engine         = cmd_decode_pkg::ENG_NONE;
         dec.interruptible  = 1'b0;
         dec.internal_state = 1'b0;
      end
   end

   // ****************************************
   // output stage
   // ****************************************
   cmd_decode_pkg::dec_t next_out;

   always_comb begin
      next_out = DECODE_OUT;
      if (accept) begin
         next_out = dec;
      end else if (DECODE_READY_IN) begin
         next_out.valid = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         DECODE_OUT <= '0;
      end else begin
         DECODE_OUT <= next_out;
      end
   end

endmodule

// ===== rtl/cmd_decode_pkg.sv
// command header decode: shared constants, enums and carrier structs
// assumes a 32-bit header dword from a command streamer on one core clock
package cmd_decode_pkg;

   // ****************************************
   // header fields
   // ****************************************
   localparam int CLIENT_HI  = 31;
   localparam int CLIENT_LO  = 29;
   localparam int BLT_OP_HI  = 28;
   localparam int BLT_OP_LO  = 22;
   localparam int PTYPE_HI   = 28;
   localparam int PTYPE_LO   = 27;
   localparam int OPC_HI     = 26;
   localparam int OPC_LO     = 24;
   localparam int SUB_HI     = 23;
   localparam int SUB_LO     = 16;
   localparam int SUBA_HI    = 23;
   localparam int SUBA_LO    = 21;
   localparam int SUBB_HI    = 20;
   localparam int SUBB_LO    = 16;
   localparam int LEN8_HI    = 7;
   localparam int LEN16_HI   = 15;

   // ****************************************
   // field codes
   // ****************************************
   localparam logic [2:0] CLIENT_MEM   = 3'h0;
   localparam logic [2:0] CLIENT_BLIT  = 3'h2;
   localparam logic [2:0] CLIENT_PIPE  = 3'h3;
   localparam logic [1:0] PTYPE_COMMON = 2'h0;
   localparam logic [1:0] PTYPE_CODEC  = 2'h2;
   localparam logic [1:0] PTYPE_3D     = 2'h3;
   localparam logic [2:0] SUBA_STATE   = 3'h0;
   localparam logic [2:0] SUBA_DEC     = 3'h1;
   localparam logic [2:0] SUBA_ENC     = 3'h2;
   localparam logic [4:0] SUBB_BSD     = 5'h08;
   localparam logic [4:0] SUBB_PACK    = 5'h09;
   localparam logic [7:0] SUB_INTERNAL = 8'h53;
   localparam logic [15:0] LEN_BIAS    = 16'h0002;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      ENG_NONE, ENG_MEM, ENG_BLIT, ENG_3D, ENG_COMMON, ENG_CODEC
   } engine_t;

   typedef enum logic [2:0] {
      CFAM_COMMON, CFAM_H264, CFAM_SMPTE, CFAM_M2V, CFAM_NONE
   } codec_family_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] header;
   } hdr_t;

   typedef struct packed {
      logic        valid;
      logic        invalid;
      engine_t     engine;
      logic [15:0] cmd_id;
      logic        interruptible;
      logic        internal_state;
      logic [15:0] length;
   } dec_t;

endpackage

// ===== rtl/blit_opcode_map.sv
// 2D opcode map: opcode -> command index and reserved flag
// assumes a 7-bit opcode already taken from the header; purely combinational
`timescale 1ns/1ps
module blit_opcode_map (
   input  wire logic [6:0] opcode_in,
   output logic            known_out,
   output logic [7:0]      cmd_index_out
);
   always_comb begin
      known_out     = 1'b1;
      cmd_index_out = {1'b0, opcode_in};
      case (opcode_in)
         7'h01, 7'h03, 7'h11 : known_out = 1'b1;
         7'h24, 7'h25, 7'h26, 7'h31 : known_out = 1'b1;
         7'h40, 7'h43 : known_out = 1'b1;
         7'h50, 7'h51, 7'h52, 7'h53, 7'h54,
         7'h55, 7'h56, 7'h57, 7'h58, 7'h59 : known_out = 1'b1;
         7'h71, 7'h72, 7'h73, 7'h74,
         7'h75, 7'h76, 7'h77 : known_out = 1'b1;
         default : begin
            known_out     = 1'b0;
            cmd_index_out = 8'h00;
         end
      endcase
   end
endmodule

// ===== rtl/codec_opcode_map.sv
// codec opcode map: opcode/subcode_a/subcode_b -> known and interruptible
// assumes fields already split from the header; purely combinational
`timescale 1ns/1ps
module codec_opcode_map (
   input  wire logic [2:0] opcode_in,
   input  wire logic [2:0] subcode_a_in,
   input  wire logic [4:0] subcode_b_in,
   output logic            known_out,
   output logic            interruptible_out
);
   logic [10:0] key;

   always_comb begin
      key               = {opcode_in, subcode_a_in, subcode_b_in};
      known_out         = 1'b0;
      interruptible_out = 1'b0;
      case (opcode_in)
         3'h0 : begin
            if (subcode_a_in == cmd_decode_pkg::SUBA_STATE &&
                subcode_b_in <= 5'h06) begin
               known_out = 1'b1;
            end
            if (subcode_a_in == cmd_decode_pkg::SUBA_DEC &&
                subcode_b_in == cmd_decode_pkg::SUBB_PACK) begin
               known_out         = 1'b1;
               interruptible_out = 1'b1;
            end
         end
         3'h1 : begin
            if (subcode_a_in == cmd_decode_pkg::SUBA_STATE && subcode_b_in <= 5'h05) begin
               known_out = 1'b1;
            end
            if (key == 11'h128 || key == 11'h142 || key == 11'h148) begin
               known_out = 1'b1;
            end
            if (key == 11'h149) begin
               known_out         = 1'b1;
               interruptible_out = 1'b1;
            end
            if (key == {3'h1, cmd_decode_pkg::SUBA_DEC, cmd_decode_pkg::SUBB_BSD}) begin
               interruptible_out = 1'b0;
            end
         end
         3'h2, 3'h3 : begin
            if (subcode_a_in == cmd_decode_pkg::SUBA_STATE && subcode_b_in <= 5'h01) begin
               known_out = 1'b1;
            end
            if (opcode_in == 3'h2 && key[7:0] == 8'h02) begin
               known_out = 1'b1;
            end
            if (subcode_a_in == cmd_decode_pkg::SUBA_DEC &&
                subcode_b_in == cmd_decode_pkg::SUBB_BSD) begin
               known_out         = 1'b1;
               interruptible_out = 1'b1;
            end
         end
         default : begin
            known_out         = 1'b0;
            interruptible_out = 1'b0;
         end
      endcase
   end
endmodule

// ===== bench/cmd_header_decoder_props.sv
// port checker for the command header decoder
// assumes one clock and an async active-low reset; bound onto the decoder
`timescale 1ns/1ps
module cmd_header_decoder_props (
   input wire logic                 CLOCK_IN,
   input wire logic                 RST_B_IN,
   input wire cmd_decode_pkg::hdr_t HEADER_IN,
   input wire logic                 HEADER_READY_OUT,
   input wire logic                 DECODE_READY_IN,
   input wire cmd_decode_pkg::dec_t DECODE_OUT
);
   // ****************************************
   // helpers
   // ****************************************
   logic        take;
   logic [31:0] h;
   logic [6:0]  bop;
   logic [7:0]  len8;
   assign take = HEADER_IN.valid && HEADER_READY_OUT;
   assign h    = HEADER_IN.header;
   assign bop  = HEADER_IN.header[28:22];
   assign len8 = HEADER_IN.header[7:0];
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_B_IN);
   // ****************************************
   // properties
   // ****************************************
   a_ready_follows: assert property (
      HEADER_READY_OUT == (!DECODE_OUT.valid || DECODE_READY_IN))
      else $error("ready does not follow output state");
   a_take_answer: assert property (
      take |=> DECODE_OUT.valid)
      else $error("no result one cycle after take");
   a_hold_stall: assert property (
      DECODE_OUT.valid && !DECODE_READY_IN |=> $stable(DECODE_OUT))
      else $error("result changed while stalled");
   a_idle_clear: assert property (
      HEADER_READY_OUT && !HEADER_IN.valid |=> !DECODE_OUT.valid)
      else $error("result without header");
   a_blit_opcode: assert property (
      take && h[31:29] == 3'h2 |=> DECODE_OUT.invalid ||
      (DECODE_OUT.engine == cmd_decode_pkg::ENG_BLIT && DECODE_OUT.cmd_id[6:0] == $past(bop)))
      else $error("blit opcode not carried");
   a_blit_reserved: assert property (
      take && h[31:29] == 3'h2 &&
      bop inside {7'h00, [7'h41:7'h42], [7'h78:7'h7F]} |=> DECODE_OUT.invalid)
      else $error("reserved blit accepted");
   a_none_engine: assert property (
      DECODE_OUT.valid && DECODE_OUT.invalid |->
      DECODE_OUT.engine == cmd_decode_pkg::ENG_NONE)
      else $error("invalid command routed");
   a_client_bad: assert property (
      take && h[31:29] inside {3'h1, [3'h4:3'h7]} |=> DECODE_OUT.invalid)
      else $error("reserved client accepted");
   a_blit_len: assert property (
      take && h[31:29] == 3'h2 |=> DECODE_OUT.invalid ||
      DECODE_OUT.length == {8'h00, $past(len8)} + 16'h0002)
      else $error("blit length wrong");
   a_h264_solid: assert property (
      take && h[31:16] == {5'h0E, 3'h1, 3'h1, 5'h08} |=>
      !DECODE_OUT.invalid && !DECODE_OUT.interruptible)
      else $error("decode object marked interruptible");
   a_pack_int: assert property (
      take && h[31:16] == {5'h0E, 3'h1, 3'h2, 5'h09} |=>
      !DECODE_OUT.invalid && DECODE_OUT.interruptible)
      else $error("pack object not interruptible");
   a_state_hole: assert property (
      take && h[31:16] == {5'h0F, 3'h0, 8'h2F} |=> DECODE_OUT.invalid)
      else $error("reserved state subcode accepted");
   a_internal_flag: assert property (
      take && h[31:16] == {5'h0F, 3'h0, 8'h53} |=>
      DECODE_OUT.internal_state && !DECODE_OUT.invalid)
      else $error("internal state not flagged");
endmodule
bind cmd_header_decoder cmd_header_decoder_props cmd_header_decoder_props_inst (
   .CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .HEADER_IN(HEADER_IN),
   .HEADER_READY_OUT(HEADER_READY_OUT), .DECODE_READY_IN(DECODE_READY_IN),
   .DECODE_OUT(DECODE_OUT));

// ===== bench/streamer_model.sv
// command streamer stand-in: offers queued header dwords, valid held until taken
// assumes ready is sampled at the rising edge; drives 1 ns after it
`timescale 1ns/1ps
module streamer_model (
   input  wire logic            clk_in,
   input  wire logic            rst_b_in,
   input  wire logic            ready_in,
   output cmd_decode_pkg::hdr_t hdr_out
);
   logic [31:0] q[$];
   logic        gappy;
   logic        free;
   initial begin
      hdr_out = '0;
      gappy = 1'b0;
   end
   // ****************************************
   // queue and beat driver
   // ****************************************
   task automatic push(input logic [31:0] h);
      q.push_back(h);
   endtask
   always @(posedge clk_in) begin
      free = !hdr_out.valid || ready_in;
      #1;
      if (!rst_b_in) hdr_out = '0;
      else if (free) begin
         if (q.size() > 0 && (!gappy || $urandom_range(3) != 0)) begin
            hdr_out = {1'b1, q.pop_front()};
         end else begin
            hdr_out = {1'b0, ~hdr_out.header}; // idle bus inverts the held dword each cycle, so it differs from the dword of the cycle before
         end
      end
   end
endmodule

// ===== bench/test_cmd_header_decoder.sv
// self-checking bench for the command header decoder
// assumes the streamer stand-in and the bound port checker
`timescale 1ns/1ps
module test_cmd_header_decoder;
   logic                 clk;
   logic                 rst_b;
   logic                 hdr_rdy;
   logic                 dec_rdy;
   logic                 stall;
   cmd_decode_pkg::hdr_t hdr;
   cmd_decode_pkg::dec_t dec;
   cmd_decode_pkg::dec_t e;
   logic [31:0]          exp_q[$];
   logic [31:0]          h;
   logic [31:0]          r;
   logic [10:0]          k;
   int                   num_errors;
   int                   num_checks;
   int                   num_results;
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      dec_rdy = 1'b1;
      stall = 1'b0;
      num_errors = 0;
      num_checks = 0;
      num_results = 0;
   end
   always #50 clk = ~clk;
   streamer_model streamer_model_inst (.clk_in(clk), .rst_b_in(rst_b), .ready_in(hdr_rdy),
      .hdr_out(hdr));
   cmd_header_decoder cmd_header_decoder_inst (.CLOCK_IN(clk), .RST_B_IN(rst_b),
      .HEADER_IN(hdr), .HEADER_READY_OUT(hdr_rdy), .DECODE_READY_IN(dec_rdy), .DECODE_OUT(dec));
   // ****************************************
   // expectation and comparison
   // ****************************************
   function automatic cmd_decode_pkg::dec_t expect_of(input logic [31:0] x);
      cmd_decode_pkg::dec_t d;
      logic                 ok;
      logic [2:0]           op;
      logic [2:0]           a;
      logic [4:0]           b;
      logic [7:0]           s;
      d = '0;
      ok = 1'b0;
      op = x[26:24];
      a = x[23:21];
      b = x[20:16];
      s = x[23:16];
      d.valid = 1'b1;
      d.length = {8'h00, x[7:0]} + 16'h0002;
      d.engine = cmd_decode_pkg::ENG_3D;
      d.cmd_id = {2'b00, x[28:27], 1'b0, x[26:16]};
      if (x[31:29] == 3'h0) begin
         ok = 1'b1;
         d.engine = cmd_decode_pkg::ENG_MEM;
         d.cmd_id = {9'h000, x[28:22]};
         d.length = {10'h000, x[5:0]} + 16'h0002;
      end else if (x[31:29] == 3'h2) begin
         ok = x[28:22] inside {7'h01, 7'h03, 7'h11, [7'h24:7'h26], 7'h31, 7'h40, 7'h43,
            [7'h50:7'h59], [7'h71:7'h77]};
         d.engine = cmd_decode_pkg::ENG_BLIT;
         d.cmd_id = {8'h20, 1'b0, x[28:22]};
      end else if (x[31:27] == 5'h0F) begin
         if (op == 3'h0) ok = s inside {[8'h04:8'h0B], 8'h0D, [8'h10:8'h20],
            [8'h22:8'h2E], [8'h30:8'h33], [8'h4C:8'h53]};
         else if (op == 3'h1) ok = s inside {8'h00, 8'h02, 8'h04, [8'h06:8'h08],
            [8'h0A:8'h18], 8'h1C, 8'h1D};
         else ok = op inside {3'h2, 3'h3} && s == 8'h00;
         d.internal_state = op == 3'h0 && s == 8'h53;
      end else if (x[31:27] == 5'h0C) begin
         ok = (op == 3'h0 && s == 8'h03) || (op == 3'h1 && s inside {[8'h01:8'h04]});
         d.engine = cmd_decode_pkg::ENG_COMMON;
      end else if (x[31:27] == 5'h0E) begin
         d.engine = cmd_decode_pkg::ENG_CODEC;
         d.cmd_id = {2'b01, x[28:27], 1'b0, x[26:16]};
         d.length = x[15:0] + 16'h0002;
         case (op)
            3'h0: ok = (a == 3'h0 && b <= 5'h06) || (a == 3'h1 && b == 5'h09);
            3'h1: ok = (a == 3'h0 && b <= 5'h05) || (a == 3'h1 && b == 5'h08) ||
               (a == 3'h2 && b inside {5'h02, 5'h08, 5'h09});
            3'h2: ok = (a == 3'h0 && b <= 5'h02) || (a == 3'h1 && b == 5'h08);
            3'h3: ok = (a == 3'h0 && b <= 5'h01) || (a == 3'h1 && b == 5'h08);
            default: ok = 1'b0;
         endcase
         d.interruptible = op == 3'h1 ? a == 3'h2 && b == 5'h09 : a == 3'h1;
      end
      if (!ok) begin
         d.invalid = 1'b1;
         d.engine = cmd_decode_pkg::ENG_NONE;
      end
      return d;
   endfunction
   task automatic cmp(input logic [15:0] g, input logic [15:0] x);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // pending queues must empty, bounded so a hang still reports
   task automatic drain();
      int n;
      n = 0;
      while ((streamer_model_inst.q.size() > 0 || hdr.valid || exp_q.size() > 0 || dec.valid)
         && n < 40000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40000) begin
         num_errors++;
         close_out();
      end
   endtask
   // ****************************************
   // consumer and monitor
   // ****************************************
   always @(posedge clk) begin
      #1;
      dec_rdy = stall ? 1'($urandom_range(1)) : 1'b1;
   end
   always @(posedge clk) begin
      if (rst_b && dec.valid && dec_rdy) begin
         num_results++;
         if (exp_q.size() == 0) begin
            cmp(16'(dec.valid), 16'h0000);
         end else begin
            e = expect_of(exp_q.pop_front());
            cmp(16'(dec.invalid), 16'(e.invalid));
            cmp(16'(dec.engine), 16'(e.engine));
            if (!e.invalid) begin
               cmp(dec.length, e.length);
               cmp(16'(dec.interruptible), 16'(e.interruptible));
               cmp(16'(dec.internal_state), 16'(e.internal_state));
               cmp(dec.cmd_id, e.cmd_id);
            end
         end
      end
      if (rst_b && hdr.valid && hdr_rdy) exp_q.push_back(hdr.header);
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'hF904DF9D));
      repeat (3) @(posedge clk);
      cmp(16'(dec.valid), 16'h0000);
      cmp(16'(hdr_rdy), 16'h0001);
      #1 rst_b = 1'b1;
      // corner: state pointer first, then the picture's decode object
      streamer_model_inst.push({5'h0E, 11'h006, 16'h0003});
      streamer_model_inst.push({5'h0E, 11'h128, 16'hFFFF});
      // first half back to back, second half with gaps and stalls
      for (int i = 0; i < 8192; i++) begin
         r = $urandom();
         k = i[10:0];
         case (i[12:11])
            2'h0: h = {5'h0F, k, r[15:0]};
            2'h1: h = {5'h0C, k, r[15:0]};
            2'h2: h = {5'h0E, k, r[15:0]};
            default: h = k[10:7] == 4'h0 ? {3'h2, k[6:0], r[21:0]} : r;
         endcase
         if (i == 4096) begin
            drain();
            stall = 1'b1;
            streamer_model_inst.gappy = 1'b1;
         end
         streamer_model_inst.push(h);
      end
      drain();
      cmp(16'(num_results), 16'h2002);
      close_out();
   end
endmodule
